// ==== design/miet_core.v ====
// instruction execution and timing core
//
// Overview of operation
// [RQ1] ordinary instructions finish in one instruction cycle.
// [RQ2] each instruction cycle is four system clocks.
// [RQ3] jump, call, both returns and table read take two cycles.
// [RQ4] writing the program counter low byte jumps and costs one extra cycle.
// [RQ5] a skip costs one cycle, or two when taken.
// [RQ6] add flags carry above 255, subtract flags borrow below zero.
// [RQ7] increment and decrement change by one, result to memory or accumulator.
// [RQ8] and, or, xor and complement set zero flag on zero result, else clear it.
// [RQ9] rotates move one bit; through-carry forms swap the end bit with carry.
// [RQ10] call saves the next address and return resumes there.
// [RQ11] jump loads the target and saves nothing.
// [RQ12] conditional skips test a byte or a bit and skip the next instruction.
// [RQ13] bit set and clear change only the selected bit of the byte.
// [RQ14] moves go memory to accumulator, accumulator to memory, or constant in.
// [RQ15] interrupt return sets global enable, plain return leaves it.
// [RQ16] a two-bit phase counter marks each cycle start on wrap to zero.
// [RQ17] multi-cycle cases insert one dummy cycle flushing the fetched word.
`include "miet_regs.vh"
`default_nettype none
module miet_core #(
   parameter PC_W = 13,
   parameter STACK_DEPTH = 8
) (
   input wire mclk_i,
   input wire reset_i,
   input wire [4:0] op_i,
   input wire [7:0] mem_rdata_i,
   input wire [7:0] imm_i,
   input wire [2:0] bit_sel_i,
   input wire [PC_W-1:0] target_i,
   input wire to_acc_i,
   input wire dest_pcl_i,
   input wire irq_enable_clr_i,
   output wire [1:0] phase_o,
   output wire cycle_start_o,
   output wire fetch_o,
   output reg [PC_W-1:0] pc_o,
   output reg [7:0] acc_o,
   output reg [7:0] mem_wdata_o,
   output reg mem_we_o,
   output reg carry_o,
   output reg zero_o,
   output reg global_irq_enable_o,
   output reg tbl_rd_o,
   output wire dummy_o
);
   localparam ST_EXEC = 2'b01;
   localparam ST_DUMMY = 2'b10;
   localparam SP_W = 3;

   wire [1:0] phase;
   wire cycle_end;
   reg [1:0] state_r;
   reg [PC_W-1:0] stack_r [0:STACK_DEPTH-1];
   reg [SP_W-1:0] sp_r;

   // wide enough for carry and borrow out
   reg [8:0] sum;
   reg [7:0] res;
   reg [7:0] operand;
   reg wr_res, wr_c, wr_z, c_nxt, two_cyc, skip, to_mem;
   reg [PC_W-1:0] pc_nxt;
   reg [PC_W-1:0] pc_inc;

   miet_phase u_phase (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .phase_o(phase),
      .cycle_end_o(cycle_end)
   );

   function [7:0] bit_mask;
      input [2:0] sel;
      begin
         bit_mask = 8'h01 << sel;
      end
   endfunction

   assign phase_o = phase;
   assign cycle_start_o = (phase == 2'h0); // [RQ16]
   assign fetch_o = cycle_end;
   assign dummy_o = (state_r == ST_DUMMY);

   always @* begin
      pc_inc = pc_o + {{(PC_W-1){1'b0}}, 1'b1};
      operand = mem_rdata_i;
      sum = 9'h000;
      res = 8'h00;
      wr_res = 1'b0;
      wr_c = 1'b0;
      wr_z = 1'b0;
      c_nxt = carry_o;
      two_cyc = 1'b0;
      skip = 1'b0;
      pc_nxt = pc_inc; // [RQ1]
      case (op_i)
         `MIET_OP_MOV_M2A: begin
            res = operand; wr_res = 1'b1; // [RQ14]
         end
         `MIET_OP_MOV_A2M: begin
            res = acc_o; wr_res = 1'b1; // [RQ14]
         end
         `MIET_OP_MOV_K2A: begin
            res = imm_i; wr_res = 1'b1; // [RQ14]
         end
         `MIET_OP_ADD, `MIET_OP_ADC: begin
            sum = {1'b0, acc_o} + {1'b0, operand}
               + {8'h00, (op_i == `MIET_OP_ADC) & carry_o};
            res = sum[7:0]; wr_res = 1'b1; wr_c = 1'b1; wr_z = 1'b1;
            c_nxt = (sum > `MIET_BYTE_MAX); // [RQ6]
         end
         `MIET_OP_SUB, `MIET_OP_SBC: begin
            // carry high means no borrow
            sum = {1'b0, acc_o} - {1'b0, operand}
               - {8'h00, (op_i == `MIET_OP_SBC) & ~carry_o};
            res = sum[7:0]; wr_res = 1'b1; wr_c = 1'b1; wr_z = 1'b1;
            c_nxt = ~sum[8]; // [RQ6]
         end
         `MIET_OP_INC: begin
            res = operand + 8'h01; wr_res = 1'b1; wr_z = 1'b1; // [RQ7]
         end
         `MIET_OP_DEC: begin
            res = operand - 8'h01; wr_res = 1'b1; wr_z = 1'b1; // [RQ7]
         end
         `MIET_OP_AND: begin
            res = acc_o & operand; wr_res = 1'b1; wr_z = 1'b1; // [RQ8]
         end
         `MIET_OP_OR: begin
            res = acc_o | operand; wr_res = 1'b1; wr_z = 1'b1; // [RQ8]
         end
         `MIET_OP_XOR: begin
            res = acc_o ^ operand; wr_res = 1'b1; wr_z = 1'b1; // [RQ8]
         end
         `MIET_OP_CPL: begin
            res = ~operand; wr_res = 1'b1; wr_z = 1'b1; // [RQ8]
         end
         `MIET_OP_RR: begin
            res = {operand[0], operand[7:1]}; wr_res = 1'b1; // [RQ9]
         end
         `MIET_OP_RL: begin
            res = {operand[6:0], operand[7]}; wr_res = 1'b1; // [RQ9]
         end
         `MIET_OP_RRC: begin
            res = {carry_o, operand[7:1]}; c_nxt = operand[0]; // [RQ9]
            wr_res = 1'b1; wr_c = 1'b1;
         end
         `MIET_OP_RLC: begin
            res = {operand[6:0], carry_o}; c_nxt = operand[7]; // [RQ9]
            wr_res = 1'b1; wr_c = 1'b1;
         end
         `MIET_OP_BCLR: begin
            res = operand & ~bit_mask(bit_sel_i); wr_res = 1'b1; // [RQ13]
         end
         `MIET_OP_BSET: begin
            res = operand | bit_mask(bit_sel_i); wr_res = 1'b1; // [RQ13]
         end
         `MIET_OP_JMP, `MIET_OP_CALL: begin
            pc_nxt = target_i; two_cyc = 1'b1; // [RQ3] [RQ11]
         end
         `MIET_OP_RET, `MIET_OP_INTERRUPT_RETURN_OP: begin
            pc_nxt = stack_r[sp_r - 3'h1]; two_cyc = 1'b1; // [RQ3] [RQ10]
         end
         `MIET_OP_TBLRD: begin
            two_cyc = 1'b1; // [RQ3]
         end
         `MIET_OP_SZ: skip = (operand == 8'h00); // [RQ12]
         `MIET_OP_SNZ: skip = (operand != 8'h00); // [RQ12]
         `MIET_OP_SZB: skip = ~operand[bit_sel_i]; // [RQ12]
         `MIET_OP_SNZB: skip = operand[bit_sel_i]; // [RQ12]
         default: begin
         end
      endcase
      if (skip) begin
         pc_nxt = pc_o + {{(PC_W-2){1'b0}}, 2'h2}; // [RQ5]
      end
      // moves and bit ops have a fixed destination, whatever to_acc_i says
      case (op_i)
         `MIET_OP_MOV_M2A, `MIET_OP_MOV_K2A: to_mem = 1'b0; // [RQ14]
         `MIET_OP_MOV_A2M, `MIET_OP_BCLR, `MIET_OP_BSET: to_mem = wr_res; // [RQ13] [RQ14]
         default: to_mem = wr_res && !to_acc_i; // [RQ7]
      endcase
      // a result sent to the low pc byte is a jump
      if (to_mem && dest_pcl_i) begin
         pc_nxt = {pc_o[PC_W-1:8], res}; // [RQ4]
         two_cyc = 1'b1;
      end
   end

   always @(posedge mclk_i) begin
      if (reset_i) begin
         state_r <= ST_EXEC;
         pc_o <= `MIET_PC_RST;
         acc_o <= `MIET_ACC_RST;
         mem_wdata_o <= 8'h00;
         mem_we_o <= 1'b0;
         carry_o <= 1'b0;
         zero_o <= 1'b0;
         global_irq_enable_o <= 1'b0;
         tbl_rd_o <= 1'b0;
         sp_r <= {SP_W{1'b0}};
      end else begin
         mem_we_o <= 1'b0;
         tbl_rd_o <= 1'b0;
         if (irq_enable_clr_i) begin
            global_irq_enable_o <= 1'b0;
         end
         if (cycle_end) begin // [RQ2]
            case (state_r)
               ST_EXEC: begin
                  pc_o <= pc_nxt;
                  if (to_mem) begin
                     mem_wdata_o <= res; // [RQ13]
                     mem_we_o <= 1'b1;
                  end else if (wr_res) begin
                     acc_o <= res; // [RQ7] [RQ14]
                  end
                  if (wr_c) carry_o <= c_nxt; // [RQ6] [RQ9]
                  if (wr_z) zero_o <= (res == 8'h00); // [RQ8]
                  if (op_i == `MIET_OP_CALL) begin
                     stack_r[sp_r] <= pc_inc; // [RQ10]
                     sp_r <= sp_r + 3'h1;
                  end
                  if (op_i == `MIET_OP_RET || op_i == `MIET_OP_INTERRUPT_RETURN_OP) begin
                     sp_r <= sp_r - 3'h1; // [RQ10]
                  end
                  if (op_i == `MIET_OP_INTERRUPT_RETURN_OP) begin
                     global_irq_enable_o <= 1'b1; // [RQ15]
                  end
                  if (op_i == `MIET_OP_TBLRD) tbl_rd_o <= 1'b1;
                  // fetched word is stale, burn one cycle
                  if (two_cyc || skip) state_r <= ST_DUMMY; // [RQ17] [RQ5]
               end
               ST_DUMMY: begin
                  state_r <= ST_EXEC; // [RQ17]
               end
               default: state_r <= ST_EXEC;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ==== design/miet_phase.v ====
// instruction cycle phase counter
`include "miet_regs.vh"
`default_nettype none
module miet_phase (
   input wire mclk_i,
   input wire reset_i,
   output wire [`MIET_PHASE_W-1:0] phase_o,
   output wire cycle_end_o
);
   reg [`MIET_PHASE_W-1:0] phase_r;
   always @(posedge mclk_i) begin
      if (reset_i) begin
         phase_r <= {`MIET_PHASE_W{1'b0}};
      end else begin
         phase_r <= phase_r + 2'h1; // [RQ16] [RQ2]
      end
   end
   assign phase_o = phase_r;
   assign cycle_end_o = (phase_r == `MIET_PHASE_LAST); // [RQ2]
endmodule
`default_nettype wire

// ==== design/miet_regs.vh ====
// constants for the instruction execution and timing core
`ifndef MIET_REGS_VH
`define MIET_REGS_VH
`define MIET_PHASES 4
`define MIET_PHASE_W 2
`define MIET_PHASE_LAST 2'h3
`define MIET_PC_RST 13'h0000
`define MIET_ACC_RST 8'h00
`define MIET_BYTE_MAX 9'h0ff
// operation codes on the decoded op port
`define MIET_OP_NOP 5'h00
`define MIET_OP_MOV_M2A 5'h01
`define MIET_OP_MOV_A2M 5'h02
`define MIET_OP_MOV_K2A 5'h03
`define MIET_OP_ADD 5'h04
`define MIET_OP_ADC 5'h05
`define MIET_OP_SUB 5'h06
`define MIET_OP_SBC 5'h07
`define MIET_OP_INC 5'h08
`define MIET_OP_DEC 5'h09
`define MIET_OP_AND 5'h0a
`define MIET_OP_OR 5'h0b
`define MIET_OP_XOR 5'h0c
`define MIET_OP_CPL 5'h0d
`define MIET_OP_RR 5'h0e
`define MIET_OP_RL 5'h0f
`define MIET_OP_RRC 5'h10
`define MIET_OP_RLC 5'h11
`define MIET_OP_BCLR 5'h12
`define MIET_OP_BSET 5'h13
`define MIET_OP_JMP 5'h14
`define MIET_OP_CALL 5'h15
`define MIET_OP_RET 5'h16
`define MIET_OP_INTERRUPT_RETURN_OP 5'h17
`define MIET_OP_TBLRD 5'h18
`define MIET_OP_SZ 5'h19
`define MIET_OP_SNZ 5'h1a
`define MIET_OP_SZB 5'h1b
`define MIET_OP_SNZB 5'h1c
`endif

// ==== tb/miet_core_monitor.sv ====
// port checker for the execution timing core
`include "miet_regs.vh"
`default_nettype none
module miet_monitor #(
   parameter PC_W = 13
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [4:0] op_i,
   input wire logic [7:0] mem_rdata_i,
   input wire logic [7:0] imm_i,
   input wire logic [2:0] bit_sel_i,
   input wire logic [PC_W-1:0] target_i,
   input wire logic [1:0] phase_o,
   input wire logic cycle_start_o,
   input wire logic fetch_o,
   input wire logic [PC_W-1:0] pc_o,
   input wire logic [7:0] acc_o,
   input wire logic [7:0] mem_wdata_o,
   input wire logic mem_we_o,
   input wire logic global_irq_enable_o,
   input wire logic dummy_o
);
   wire tk = phase_o == 2'h3 && !dummy_o;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   phase_step_a: assert property (1'b1 |=> phase_o == $past(phase_o) + 2'h1)
      else $error("phase did not step");
   cycle_mark_a: assert property (cycle_start_o |=> !cycle_start_o [*3] ##1 cycle_start_o)
      else $error("cycle start spacing wrong");
   fetch_mark_a: assert property (fetch_o |=> cycle_start_o && !fetch_o)
      else $error("fetch strobe not last phase");
   jump_dummy_a: assert property (tk && op_i == `MIET_OP_JMP |=> dummy_o && pc_o == $past(target_i))
      else $error("jump target or dummy wrong");
   dummy_len_a: assert property ($rose(dummy_o) |-> dummy_o [*4] ##1 !dummy_o)
      else $error("dummy cycle length wrong");
   move_single_a: assert property (tk && op_i == `MIET_OP_MOV_K2A |=> !dummy_o && acc_o == $past(imm_i))
      else $error("constant move wrong");
   skip_taken_a: assert property (tk && op_i == `MIET_OP_SZ && mem_rdata_i == 8'h00
      |=> dummy_o && pc_o == PC_W'($past(pc_o) + 2)) else $error("taken skip wrong");
   skip_none_a: assert property (tk && op_i == `MIET_OP_SZ && mem_rdata_i != 8'h00 |=> !dummy_o)
      else $error("untaken skip stalled");
   interrupt_return_op_enable_a: assert property (tk && op_i == `MIET_OP_INTERRUPT_RETURN_OP |=> global_irq_enable_o)
      else $error("enable not set on return");
   bit_clear_a: assert property (tk && op_i == `MIET_OP_BCLR |=> mem_we_o
      && mem_wdata_o == ($past(mem_rdata_i) & ~(8'h01 << $past(bit_sel_i))))
      else $error("bit clear wrong");
   dummy_hold_a: assert property (phase_o == 2'h3 && dummy_o |=> $stable(pc_o) && $stable(acc_o))
      else $error("state moved in dummy cycle");
endmodule
bind miet_core miet_monitor #(.PC_W(PC_W)) mon (.mclk_i(mclk_i), .reset_i(reset_i),
   .op_i(op_i), .mem_rdata_i(mem_rdata_i), .imm_i(imm_i), .bit_sel_i(bit_sel_i),
   .target_i(target_i), .phase_o(phase_o), .cycle_start_o(cycle_start_o),
   .fetch_o(fetch_o), .pc_o(pc_o),
   .acc_o(acc_o), .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o),
   .global_irq_enable_o(global_irq_enable_o), .dummy_o(dummy_o));
`default_nettype wire

// ==== tb/miet_core_tb.sv ====
// self-checking bench for the execution timing core
`include "miet_regs.vh"
`default_nettype none
module miet_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 0, reset_i = 1, to_acc_i = 0, dest_pcl_i = 0, irq_enable_clr_i = 0;
   logic [4:0] op_i = 0, op;
   logic [7:0] mem_rdata_i = 0, imm_i = 0, e_acc = 0, e_wd;
   logic [2:0] bit_sel_i = 0, sp = 0;
   logic [12:0] target_i = 0, e_pc = 0, stk [8];
   logic e_c = 0, e_z = 0, e_ie = 0, e_we, lg;
   wire [1:0] phase_o;
   wire [12:0] pc_o;
   wire [7:0] acc_o, mem_wdata_o;
   wire cycle_start_o, fetch_o, mem_we_o, carry_o, zero_o, global_irq_enable_o, tbl_rd_o, dummy_o;
   int n_fail = 0, total_checks = 0, e_gap = 0, dep = 0;
   time t_last = 0;
   miet_core uut (.mclk_i(mclk_i), .reset_i(reset_i), .op_i(op_i), .mem_rdata_i(mem_rdata_i),
      .imm_i(imm_i), .bit_sel_i(bit_sel_i), .target_i(target_i), .to_acc_i(to_acc_i),
      .dest_pcl_i(dest_pcl_i), .irq_enable_clr_i(irq_enable_clr_i), .phase_o(phase_o),
      .cycle_start_o(cycle_start_o), .fetch_o(fetch_o), .pc_o(pc_o), .acc_o(acc_o),
      .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .carry_o(carry_o), .zero_o(zero_o),
      .global_irq_enable_o(global_irq_enable_o), .tbl_rd_o(tbl_rd_o), .dummy_o(dummy_o));
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, e);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic chk_gap(input int g, e);
      total_checks++;
      if (g != e) begin
         n_fail++;
         $display("mismatch at %0t: gap %0d want %0d", $time, g, e);
      end
   endtask
   // f packs {clear enable, pc low destination, to accumulator}
   function automatic void predict(logic [4:0] op, logic [7:0] m, k, logic [2:0] f);
      logic [7:0] res;
      logic [12:0] nx;
      logic [1:0] dst;
      logic cy, sk;
      {res, cy, dst, nx, lg} = {m, e_c, f[0] ? 2'h1 : 2'h2, e_pc + 13'h1, 1'b0};
      if (f[2]) e_ie = 0;
      case (op)
         `MIET_OP_MOV_M2A: dst = 2'h1;
         `MIET_OP_MOV_A2M: {dst, res} = {2'h2, e_acc};
         `MIET_OP_MOV_K2A: {dst, res} = {2'h1, k};
         `MIET_OP_ADD, `MIET_OP_ADC: {cy, res} = e_acc + m + (op[0] & e_c);
         `MIET_OP_SUB, `MIET_OP_SBC: {cy, res} = {1'b1, e_acc} - m - (op[0] & !e_c);
         `MIET_OP_INC: res = m + 8'h01;
         `MIET_OP_DEC: res = m - 8'h01;
         `MIET_OP_AND: {lg, res} = {1'b1, e_acc & m};
         `MIET_OP_OR: {lg, res} = {1'b1, e_acc | m};
         `MIET_OP_XOR: {lg, res} = {1'b1, e_acc ^ m};
         `MIET_OP_CPL: {lg, res} = {1'b1, ~m};
         `MIET_OP_RR: res = {m[0], m[7:1]};
         `MIET_OP_RL: res = {m[6:0], m[7]};
         `MIET_OP_RRC: {res, cy} = {e_c, m};
         `MIET_OP_RLC: {cy, res} = {m, e_c};
         `MIET_OP_BCLR: {dst, res} = {2'h2, m & ~(8'h01 << k[2:0])};
         `MIET_OP_BSET: {dst, res} = {2'h2, m | (8'h01 << k[2:0])};
         default: dst = 2'h0;
      endcase
      sk = (op < `MIET_OP_SZB) ? (m == 8'h00) : !m[k[2:0]];
      if (op == `MIET_OP_SNZ || op == `MIET_OP_SNZB) sk = !sk;
      sk = sk && op >= `MIET_OP_SZ;
      if (sk) nx = e_pc + 13'h2;
      if (op == `MIET_OP_JMP || op == `MIET_OP_CALL) nx = {k[4:0], m};
      if (op == `MIET_OP_CALL) stk[sp++] = e_pc + 13'h1;
      if (op == `MIET_OP_RET || op == `MIET_OP_INTERRUPT_RETURN_OP) nx = stk[--sp];
      dep = dep + (op == `MIET_OP_CALL) - (op == `MIET_OP_RET || op == `MIET_OP_INTERRUPT_RETURN_OP);
      if (op == `MIET_OP_INTERRUPT_RETURN_OP) e_ie = 1;
      if (dst == 2'h2 && f[1]) nx = {e_pc[12:8], res};
      e_gap = (op >= `MIET_OP_JMP && op <= `MIET_OP_TBLRD || sk || dst == 2'h2 && f[1]) ? 32 : 16;
      e_we = dst == 2'h2 && !f[1];
      if (dst == 2'h1) e_acc = res;
      if (lg) e_z = res == 8'h00;
      {e_c, e_pc, e_wd} = {cy, nx, res};
   endfunction
   // catches the very next free slot, so op spacing is what the core allows
   task automatic run(input logic [4:0] op, input logic [7:0] m, k, input logic [2:0] f);
      do @(negedge mclk_i); while (phase_o !== 2'h2 || dummy_o !== 1'b0);
      @(posedge mclk_i);
      {op_i, mem_rdata_i, imm_i, bit_sel_i} <= {op, m, k, k[2:0]};
      {target_i, irq_enable_clr_i, dest_pcl_i, to_acc_i} <= {k[4:0], m, f};
      @(posedge mclk_i);
      // clear request is a level: hold it for the taking edge only
      irq_enable_clr_i <= 1'b0;
      if (e_gap != 0) chk_gap(int'($time - t_last), e_gap);
      t_last = $time;
      @(negedge mclk_i);
      predict(op, m, k, f);
      chk(16'(acc_o), 16'(e_acc));
      chk(16'(pc_o), 16'(e_pc));
      chk(16'({carry_o, global_irq_enable_o}), 16'({e_c, e_ie}));
      chk(16'(tbl_rd_o), 16'(op == `MIET_OP_TBLRD));
      if (lg) chk(16'(zero_o), 16'(e_z));
      if (!f[1]) chk(16'(mem_we_o), 16'(e_we));
      if (e_we) chk(16'(mem_wdata_o), 16'(e_wd));
   endtask
   initial forever #2 mclk_i = ~mclk_i;
   initial begin
      #40000;
      n_fail++;
      give_verdict;
   end
   initial begin
      void'($urandom(39787));
      repeat (12) @(posedge mclk_i);
      reset_i <= 0;
      @(negedge mclk_i);
      chk(16'({pc_o, phase_o}), 16'h0000);
      run(`MIET_OP_MOV_K2A, 8'h00, 8'hff, 3'h1);
      run(`MIET_OP_ADD, 8'h01, 8'h00, 3'h1);
      run(`MIET_OP_SUB, 8'h01, 8'h00, 3'h1);
      run(`MIET_OP_SBC, 8'hff, 8'h00, 3'h0);
      run(`MIET_OP_AND, 8'h00, 8'h00, 3'h1);
      run(`MIET_OP_CPL, 8'h5a, 8'h00, 3'h0);
      run(`MIET_OP_RLC, 8'h80, 8'h00, 3'h1);
      run(`MIET_OP_BCLR, 8'hff, 8'h07, 3'h0);
      run(`MIET_OP_SZ, 8'h00, 8'h00, 3'h0);
      run(`MIET_OP_SZ, 8'h10, 8'h00, 3'h0);
      run(`MIET_OP_SNZB, 8'h04, 8'h02, 3'h0);
      run(`MIET_OP_JMP, 8'h34, 8'h12, 3'h0);
      run(`MIET_OP_CALL, 8'h00, 8'h01, 3'h0);
      run(`MIET_OP_INTERRUPT_RETURN_OP, 8'h00, 8'h00, 3'h4);
      run(`MIET_OP_NOP, 8'h00, 8'h00, 3'h4);
      run(`MIET_OP_CALL, 8'h00, 8'h02, 3'h0);
      run(`MIET_OP_RET, 8'h00, 8'h00, 3'h0);
      run(`MIET_OP_MOV_A2M, 8'h00, 8'h00, 3'h2);
      run(`MIET_OP_BCLR, 8'h81, 8'h00, 3'h3);
      for (int i = 0; i < 400; i++) begin
         op = 5'($urandom_range(28));
         // keep the stack within its depth so returns stay predictable
         if (op == `MIET_OP_CALL && dep == 8 || op[4:1] == 4'hb && dep == 0) op = `MIET_OP_NOP;
         run(op, 8'($urandom), 8'($urandom), 3'($urandom) & 3'h5);
      end
      give_verdict;
   end
endmodule
`default_nettype wire
